//--- rtl/uer_pkg.sv
/*
  constants, register map, field positions and receiver states of the
  receive error status block of an asynchronous serial receiver.
  assumes a single 10 MHz peripheral clock and a plain register port.
*/
// What this block does
// - flags in status bits zero to three
// - status view is read only, writes clear
// - overrun when character ends with fifo full
// - overrun keeps fifo entries, drops the new character
// - break when line low beyond one frame
// - break pushes one zero character, waits mark
// - parity flag on mismatch with control bits
// - framing flag when stop bit reads zero
// - character errors travel with fifo entry
// - clear write clears all four flags; an overrun in the same cycle still sets
// - error view follows last data read
// - overrun flag rises at once
// - reset clears all four flags
package uer_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000; // peripheral clock rate in hertz
  localparam int BAUD_RATE = 115_200; // default line rate in bits per second
  localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE; // clock cycles per bit
  localparam int DATA_BITS = 8; // data bits per character
  localparam int FIFO_DEPTH = 16; // receive fifo entries

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12; // register address width
  localparam logic [11:0] OFS_DATA = 12'h000; // serial_data_port
  localparam logic [11:0] OFS_ERR = 12'h004; // receive_error_status / receive_error_clear
  localparam logic [11:0] OFS_LINE = 12'h02C; // line_control
  localparam logic [11:0] OFS_IMASK = 12'h038; // interrupt mask
  localparam logic [11:0] OFS_ISTAT = 12'h03C; // sticky interrupt status, write one to clear

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ERR_FRAMING = 0; // framing_flag
  localparam int ERR_PARITY = 1; // parity_flag
  localparam int ERR_BREAK = 2; // break_flag
  localparam int ERR_OVERRUN = 3; // overrun flag
  localparam int LC_PARITY_EN = 1; // parity enable
  localparam int LC_EVEN = 2; // even parity select
  localparam int LC_FIFO_EN = 4; // fifo enable
  localparam int LC_STICK = 7; // stick parity
  localparam int INT_W = 5; // interrupt field width
  localparam int INT_RX = 0; // character received
  localparam int INT_FRAMING = 1; // framing error seen
  localparam int INT_PARITY = 2; // parity error seen
  localparam int INT_BREAK = 3; // break seen
  localparam int INT_OVERRUN = 4; // overrun seen

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ERR_RST = 4'h0;
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [4:0] INT_RST = 5'h00;

  // ----------------------------------------------------------------
  // receiver states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100,
    ST_BRK_CHK = 3'b101,
    ST_BRK_WAIT = 3'b110
  } uer_state_type;

endpackage

//--- rtl/uer_fifo.sv
/*
  receive fifo: flip-flop storage, head visible without a pop.
  assumes the caller never pushes when full and never pops when empty.
*/
`timescale 1ns/1ps
module uer_fifo
#(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic [$clog2(DEPTH+1)-1:0] count_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH]; // entries
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr, next_rd_ptr; // current head
  logic [CW-1:0] count, next_count; // occupancy

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pointers wrap explicitly so a depth that is no power of two works
  always_comb
  begin
    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push_i)
    begin
      next_mem[wr_ptr] = push_data_i;
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop_i)
    begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
    end
    if (push_i && !pop_i)
    begin
      next_count = count + CW'(1);
    end
    else if (pop_i && !push_i)
    begin
      next_count = count - CW'(1);
    end
  end

  // registers only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  assign head_o = mem[rd_ptr];
  assign count_o = count;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_fifo_bound;
    @(posedge clk_i) disable iff (rst_i) count <= CW'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

  property p_fifo_no_overwrite;
    @(posedge clk_i) disable iff (rst_i)
      (count == CW'(DEPTH)) && !push_i && !pop_i |=> $stable(mem[rd_ptr]);
  endproperty
  a_fifo_no_overwrite: assert property (p_fifo_no_overwrite) else $error("full fifo head changed");

endmodule

//--- rtl/uer_rx_status.sv
/*
  serial receiver with receive error flags of the last read character, sticky overrun, receive fifo,
  line control and interrupt status behind a plain register port.
  assumes a single-cycle strobe master on clk_i and an asynchronous
  serial input on rx_i at the rate given by BIT_CYCLES.
*/
// The strobed register port was decided locally.
`timescale 1ns/1ps
module uer_rx_status
#(
  parameter int BIT_CYCLES_P = uer_pkg::BIT_CYCLES,
  parameter int FIFO_DEPTH_P = uer_pkg::FIFO_DEPTH
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [uer_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rd_data_o,
  // serial line
  input wire logic rx_i,
  // interrupt
  output logic irq_o
);
  import uer_pkg::*;

  // ----------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------
  localparam int FW = DATA_BITS + 3; // fifo entry: break, parity, framing, data
  localparam int CW = $clog2(FIFO_DEPTH_P + 1);
  localparam logic [15:0] BIT_TICKS = 16'(BIT_CYCLES_P - 1); // full bit reload
  localparam logic [15:0] HALF_TICKS = 16'(BIT_CYCLES_P / 2 - 1); // half bit reload
  localparam logic [3:0] LAST_BIT = 4'(DATA_BITS - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rx_m1, rx_m2, rx_m3; // three-stage synchroniser
  logic rx_s, next_rx_s; // filtered line level
  logic rx_prev; // filtered level one cycle earlier, for edge detect
  uer_state_type state, next_state; // receiver state
  logic [15:0] tick, next_tick; // cycles to next sample point
  logic [3:0] bit_idx, next_bit_idx; // data bit being sampled
  logic [DATA_BITS-1:0] shift, next_shift; // receive shift register
  logic par_bit, next_par_bit; // sampled parity bit
  logic par_en; // parity enabled
  logic par_expect; // parity bit that the line should carry
  logic char_done; // one-cycle pulse: a character is complete
  logic char_fe, char_pe, char_be; // errors of that character
  logic [3:0] err, next_err; // receive_error_status flags
  logic [7:0] line_ctrl, next_line_ctrl; // line_control
  logic [INT_W-1:0] int_mask, next_int_mask; // interrupt mask
  logic [INT_W-1:0] int_stat, next_int_stat; // sticky interrupt status
  logic next_irq; // interrupt level to register
  logic [31:0] next_rd_data; // read answer to register
  logic fifo_full; // fifo (or one-entry holding register) full
  logic ovr_evt; // character lost to a full fifo
  logic push, pop; // fifo strobes
  logic data_rd; // read of serial_data_port
  logic err_clr; // write to receive_error_clear
  logic [FW-1:0] head; // fifo head entry
  logic [CW-1:0] count; // fifo occupancy

  // ----------------------------------------------------------------
  // line synchroniser
  // ----------------------------------------------------------------
  // the filtered level moves only when stages two and three agree
  always_comb
  begin
    next_rx_s = (rx_m2 == rx_m3) ? rx_m2 : rx_s;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_m1 <= 1'b1;
      rx_m2 <= 1'b1;
      rx_m3 <= 1'b1;
      rx_s <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_m1 <= rx_i;
      rx_m2 <= rx_m1;
      rx_m3 <= rx_m2;
      rx_s <= next_rx_s;
      rx_prev <= rx_s;
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // samples mid-bit; stick parity forces the bit to the inverse of even
  always_comb
  begin
    par_en = line_ctrl[LC_PARITY_EN];
    par_expect = line_ctrl[LC_STICK] ? !line_ctrl[LC_EVEN] :
                 (line_ctrl[LC_EVEN] ? ^shift : ~^shift);
    next_state = state;
    next_tick = (tick != 16'h0000) ? tick - 16'h0001 : tick;
    next_bit_idx = bit_idx;
    next_shift = shift;
    next_par_bit = par_bit;
    char_done = 1'b0;
    char_fe = 1'b0;
    char_pe = 1'b0;
    char_be = 1'b0;
    case (state)
      ST_IDLE:
      begin
        // only a falling edge starts a frame, never a line already low
        if (!rx_s && rx_prev)
        begin
          next_state = ST_START;
          next_tick = HALF_TICKS;
        end
      end
      ST_START:
      begin
        if (tick == 16'h0000)
        begin
          next_state = rx_s ? ST_IDLE : ST_DATA; // glitch returns to idle
          next_tick = BIT_TICKS;
          next_bit_idx = 4'h0;
        end
      end
      ST_DATA:
      begin
        if (tick == 16'h0000)
        begin
          next_shift = {rx_s, shift[DATA_BITS-1:1]}; // lsb first
          next_tick = BIT_TICKS;
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx == LAST_BIT)
          begin
            next_state = par_en ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY:
      begin
        if (tick == 16'h0000)
        begin
          next_par_bit = rx_s;
          next_tick = BIT_TICKS;
          next_state = ST_STOP;
        end
      end
      ST_STOP:
      begin
        if (tick == 16'h0000)
        begin
          if (!rx_s && (shift == '0) && (!par_en || !par_bit))
          begin
            // all low so far: see whether it outlasts the frame
            next_state = ST_BRK_CHK;
            next_tick = HALF_TICKS;
          end
          else
          begin
            char_done = 1'b1;
            char_fe = !rx_s;
            char_pe = par_en && (par_bit != par_expect);
            next_state = ST_IDLE;
          end
        end
      end
      ST_BRK_CHK:
      begin
        if (rx_s)
        begin
          // line rose before the frame ended: an ordinary bad character
          char_done = 1'b1;
          char_fe = 1'b1;
          char_pe = par_en && (par_bit != par_expect);
          next_state = ST_IDLE;
        end
        else if (tick == 16'h0000)
        begin
          char_done = 1'b1;
          char_be = 1'b1;
          char_fe = 1'b1;
          char_pe = par_en && (par_bit != par_expect);
          next_state = ST_BRK_WAIT;
        end
      end
      ST_BRK_WAIT:
      begin
        // nothing more is taken until the line marks again
        if (rx_s)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      tick <= 16'h0000;
      bit_idx <= 4'h0;
      shift <= '0;
      par_bit <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tick <= next_tick;
      bit_idx <= next_bit_idx;
      shift <= next_shift;
      par_bit <= next_par_bit;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  // with the fifo off the same storage acts as a one-entry holding register
  assign fifo_full = line_ctrl[LC_FIFO_EN] ? (count == CW'(FIFO_DEPTH_P)) : (count != '0);
  assign ovr_evt = char_done && fifo_full;
  assign push = char_done && !fifo_full;
  assign data_rd = rd_i && (addr_i == OFS_DATA);
  assign pop = data_rd && (count != '0);
  assign err_clr = wr_i && (addr_i == OFS_ERR);

  uer_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH_P)) u_fifo
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .push_data_i({char_be, char_pe, char_fe, shift}),
    .pop_i(pop),
    .head_o(head),
    .count_o(count)
  );

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  // the overrun set is applied last so it wins over a clear in the same cycle
  always_comb
  begin
    next_err = err;
    if (pop)
    begin
      next_err[ERR_BREAK:ERR_FRAMING] = head[FW-1:DATA_BITS];
    end
    if (err_clr)
    begin
      next_err = ERR_RST;
    end
    if (ovr_evt)
    begin
      next_err[ERR_OVERRUN] = 1'b1;
    end
    next_line_ctrl = (wr_i && (addr_i == OFS_LINE)) ? wr_data_i[7:0] : line_ctrl;
    next_int_mask = (wr_i && (addr_i == OFS_IMASK)) ? wr_data_i[INT_W-1:0] : int_mask;
    next_int_stat = int_stat;
    if (wr_i && (addr_i == OFS_ISTAT))
    begin
      next_int_stat = int_stat & ~wr_data_i[INT_W-1:0];
    end
    next_int_stat[INT_RX] = next_int_stat[INT_RX] | push;
    next_int_stat[INT_FRAMING] = next_int_stat[INT_FRAMING] | (push && char_fe);
    next_int_stat[INT_PARITY] = next_int_stat[INT_PARITY] | (push && char_pe);
    next_int_stat[INT_BREAK] = next_int_stat[INT_BREAK] | (push && char_be);
    next_int_stat[INT_OVERRUN] = next_int_stat[INT_OVERRUN] | ovr_evt;
    next_irq = |(next_int_stat & next_int_mask);
    // read answer stands for exactly one cycle; unmapped reads give zero
    next_rd_data = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        OFS_DATA: next_rd_data = (count != '0) ? {20'h0_0000, err[ERR_OVERRUN], head} : '0;
        OFS_ERR: next_rd_data = {28'h000_0000, err};
        OFS_LINE: next_rd_data = {24'h00_0000, line_ctrl};
        OFS_IMASK: next_rd_data = {27'h000_0000, int_mask};
        OFS_ISTAT: next_rd_data = {27'h000_0000, int_stat};
        default: next_rd_data = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err <= ERR_RST;
      line_ctrl <= LINE_RST;
      int_mask <= INT_RST;
      int_stat <= INT_RST;
      irq_o <= 1'b0;
      rd_data_o <= 32'h0000_0000;
    end
    else
    begin
      err <= next_err;
      line_ctrl <= next_line_ctrl;
      int_mask <= next_int_mask;
      int_stat <= next_int_stat;
      irq_o <= next_irq;
      rd_data_o <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i) rd_i && (addr_i == OFS_ERR) |=> rd_data_o[31:4] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("status upper bits set");

  property p_clear_all;
    @(posedge clk_i) disable iff (rst_i) err_clr && !ovr_evt |=> err == 4'h0;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear write left a flag");

  property p_write_no_load;
    @(posedge clk_i) disable iff (rst_i) err_clr && ovr_evt |=> err == 4'h8;
  endproperty
  a_write_no_load: assert property (p_write_no_load) else $error("write loaded status");

  property p_overrun_now;
    @(posedge clk_i) disable iff (rst_i) ovr_evt |=> err[ERR_OVERRUN] && irq_o == |(int_stat & int_mask);
  endproperty
  a_overrun_now: assert property (p_overrun_now) else $error("overrun flag late");

  property p_overrun_keep;
    @(posedge clk_i) disable iff (rst_i) ovr_evt && !pop |=> $stable(count);
  endproperty
  a_overrun_keep: assert property (p_overrun_keep) else $error("overrun changed fifo");

  property p_break_zero;
    @(posedge clk_i) disable iff (rst_i) char_done && char_be |-> shift == '0 ##1 state == ST_BRK_WAIT;
  endproperty
  a_break_zero: assert property (p_break_zero) else $error("break char not zero");

  property p_break_quiet;
    @(posedge clk_i) disable iff (rst_i) state == ST_BRK_WAIT && !rx_s |-> !char_done;
  endproperty
  a_break_quiet: assert property (p_break_quiet) else $error("char during break");

  property p_read_follows;
    @(posedge clk_i) disable iff (rst_i) pop |=> err[2:0] == $past(head[FW-1:DATA_BITS]);
  endproperty
  a_read_follows: assert property (p_read_follows) else $error("status not from last read");

  property p_read_quiet;
    @(posedge clk_i) disable iff (rst_i)
      rd_i && (addr_i == OFS_ERR) && !ovr_evt ##1 !ovr_evt [*2] |-> $stable(err);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed flags");

  property p_frame_flag;
    @(posedge clk_i) disable iff (rst_i) state == ST_STOP && tick == 16'h0000 && rx_s |-> !char_fe;
  endproperty
  a_frame_flag: assert property (p_frame_flag) else $error("framing flag on good stop");

  c_overrun: cover property (@(posedge clk_i) disable iff (rst_i) ovr_evt);
  c_break: cover property (@(posedge clk_i) disable iff (rst_i) char_done && char_be);
  c_parity_read: cover property (@(posedge clk_i) disable iff (rst_i) pop && head[FW-2]);
  c_clear: cover property (@(posedge clk_i) disable iff (rst_i) err_clr && err != 4'h0);

endmodule

//--- verif/uer_tx_model.sv
/*
  remote serial transmitter model that drives the receive line.
  assumes one clock shared with the bench; a bit lasts BITC cycles.
*/
`timescale 1ns/1ps
module uer_tx_model
#(
  parameter int BITC = 8
)
(
  // clock
  input wire logic clk_i,
  // serial line, idle high
  output logic line_o
);
  // ----------------------------------------------------------------
  // frame sender
  // ----------------------------------------------------------------
  initial line_o = 1'b1; // marking from time zero

  // hold one level for n bit times, changed just after an edge
  task automatic hold(input logic v, input int n);
    line_o <= v;
    repeat (n * BITC) @(posedge clk_i);
  endtask

  // start bit, nb bits lsb first, stop level, then idle so the push lands
  task automatic send(input logic [8:0] d, input int nb, input logic stp);
    @(posedge clk_i);
    hold(1'b0, 1);
    for (int i = 0; i < nb; i++)
      hold(d[i], 1);
    hold(stp, 1);
    hold(1'b1, 3);
  endtask
endmodule

//--- verif/uart_receive_error_status_tb_top.sv
/*
  self-checking bench of the receive error status block.
  assumes the design package and a transmitter model on the line.
*/
`timescale 1ns/1ps
module uart_receive_error_status_tb_top;
  import uer_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int BITC = 8; // short bit time keeps the run brief
  localparam int DEPTH = 4; // small fifo reaches overrun fast
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wr_data_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rd_data_o;
  logic rx_i;
  logic irq_o;
  int error_cnt = 0;
  int compares = 0;
  logic [31:0] seed = 32'h268e_0af8; // fixed seed, repeatable run
  logic [31:0] got;
  logic [7:0] b;
  logic [7:0] lc;
  logic flip;
  logic [7:0] q [$];

  initial forever #50 clk_i = ~clk_i; // 10 MHz

  uer_rx_status #(.BIT_CYCLES_P(BITC), .FIFO_DEPTH_P(DEPTH)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .rx_i(rx_i), .irq_o(irq_o));

  uer_tx_model #(.BITC(BITC)) u_tx (.clk_i(clk_i), .line_o(rx_i));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lfsr step for random data
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // parity bit a correct sender puts on the line
  function automatic logic expp(input logic [7:0] d, input logic [7:0] c);
    if (c[7])
      return ~c[2]; // stick parity
    return c[2] ? ^d : ~^d;
  endfunction

  // one-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // one-cycle read strobe; data stand only in the next cycle
  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rd_data_o;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_ERR);
    chk(got, 32'h0000_0000);
    rd(12'h100);
    chk(got, 32'h0000_0000);
    $display("test reset done");
    // good character raises the interrupt, clear drops it
    wr(OFS_LINE, 32'h0000_0016);
    wr(OFS_IMASK, 32'h0000_0001);
    b = 8'(rnd());
    u_tx.send({expp(b, 8'h16), b}, 9, 1'b1);
    chk({31'h0, irq_o}, 32'h0000_0001);
    wr(OFS_ISTAT, 32'h0000_001f);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd(OFS_DATA);
    chk(got, {24'h0, b});
    $display("test irq done");
    // every parity mode, parity right or wrong at random
    for (int i = 0; i < 8; i++)
    begin
      lc = {i[1], 2'b00, 1'b1, 1'b0, i[0], 2'b10}; // stick, fifo, even, parity on
      flip = rnd() & 1;
      b = 8'(rnd());
      wr(OFS_LINE, {24'h0, lc});
      u_tx.send({expp(b, lc) ^ flip, b}, 9, 1'b1);
      rd(OFS_DATA);
      chk(got, {22'h0, flip, 1'b0, b});
      rd(OFS_ERR);
      chk(got, {30'h0, flip, 1'b0});
      rd(OFS_ERR);
      chk(got, {30'h0, flip, 1'b0});
      wr(OFS_ERR, rnd());
      rd(OFS_ERR);
      chk(got, 32'h0000_0000);
    end
    $display("test parity done");
    // bad stop bit then a good one, flags follow each entry
    wr(OFS_LINE, 32'h0000_0010);
    u_tx.send(9'h0a5, 8, 1'b0);
    u_tx.send(9'h05a, 8, 1'b1);
    rd(OFS_DATA);
    chk(got, 32'h0000_01a5);
    rd(OFS_ERR);
    chk(got, 32'h0000_0001);
    rd(OFS_DATA);
    chk(got, 32'h0000_005a);
    wr(OFS_ERR, 32'h0000_0000);
    $display("test framing done");
    // break: one zero entry, then a fresh character is taken
    u_tx.hold(1'b0, 30);
    u_tx.hold(1'b1, 3);
    rd(OFS_DATA);
    chk(got, 32'h0000_0500);
    rd(OFS_DATA);
    chk(got, 32'h0000_0000);
    rd(OFS_ERR);
    chk(got, 32'h0000_0005);
    wr(OFS_ERR, 32'hffff_ffff);
    u_tx.send(9'h03c, 8, 1'b1);
    rd(OFS_DATA);
    chk(got, 32'h0000_003c);
    $display("test break done");
    // overrun: fifo full plus one, old entries kept
    for (int i = 0; i <= DEPTH; i++)
    begin
      b = 8'(rnd());
      q.push_back(b);
      u_tx.send({1'b0, b}, 8, 1'b1);
    end
    rd(OFS_ERR);
    chk(got, 32'h0000_0008);
    @(posedge clk_i);
    #1 chk(rd_data_o, 32'h0000_0000);
    wr(OFS_ERR, rnd());
    for (int i = 0; i < DEPTH; i++)
    begin
      rd(OFS_DATA);
      chk(got, {24'h0, q.pop_front()});
    end
    rd(OFS_DATA);
    chk(got, 32'h0000_0000);
    u_tx.send(9'h0c3, 8, 1'b1);
    rd(OFS_DATA);
    chk(got, 32'h0000_00c3);
    $display("test overrun done");
    close_out();
  end
endmodule
